// >>> inc/dcc_pkg.sv
// Constants and carrier types for the deserializer channel config bank.
// Assumes a 100 MHz mclk and a register port driven by the local
// serial-bus slave that lives outside this block.
package dcc_pkg;
    // -----------------------------------------------------------------
    // Register offsets and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] GEN_CFG_ONE_OFS  = 8'h03;
    localparam logic [7:0] WDOG_CTRL_OFS    = 8'h04;
    localparam logic [7:0] BUS_CTRL_ONE_OFS = 8'h05;
    localparam logic [7:0] GEN_CFG_ONE_RST  = 8'hF0;
    localparam logic [7:0] WDOG_CTRL_RST    = 8'hFE;
    localparam logic [7:0] BUS_CTRL_ONE_RST = 8'h1E;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;
    // Writable bits of general_config_one; bits 7 and 0 are reserved
    localparam logic [7:0] GEN_CFG_ONE_WMSK = 8'h7E;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int CRC_GEN_BIT    = 6;
    localparam int PULL_DOWN_BIT  = 5;
    localparam int STROBE_FLT_BIT = 4;
    localparam int PASS_ALIAS_BIT = 3;
    localparam int AUTO_ACK_BIT   = 2;
    localparam int GATE_PIX_BIT   = 1;
    localparam int WDOG_TMO_MSB   = 7;
    localparam int WDOG_TMO_LSB   = 1;
    localparam int WDOG_OFF_BIT   = 0;
    localparam int PASS_ALL_BIT   = 7;
    localparam int SDA_HOLD_MSB   = 6;
    localparam int SDA_HOLD_LSB   = 4;
    localparam int GLITCH_MSB     = 3;
    localparam int GLITCH_LSB     = 0;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int WDOG_STEP_MS   = 2;
    localparam int WDOG_STEP_CYC  = WDOG_STEP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SDA_HOLD_NS    = 50;
    localparam int GLITCH_STEP_NS = 5;
    localparam int STROBE_MIN_PIX = 2;  // Pixel periods a pulse must last
    localparam int HOLD_TAPS      = 36; // 7 steps * 50 ns / 10 ns + 1
    localparam int FLT_CNT_W      = 6;

    // -----------------------------------------------------------------
    // Carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        pixelValidStrobe;
        logic        horizontalSync;
        logic        verticalSync;
        logic [23:0] rgb;
    } dcc_pixel_t;

    typedef struct packed {
        logic [6:0] aliasAddressEntry;
        logic [6:0] physicalAddress;
    } dcc_alias_t;
endpackage : dcc_pkg

// >>> src/dcc_channel_config_regs.sv
// Channel configuration bank: three registers plus the logic they steer
// (strobe filter, pixel gating, alias forwarding, watchdog, SCL/SDA
// conditioning). Assumes a single 100 MHz mclk, a pixel-clock enable
// pulse, and a register port from the local serial-bus slave.
`timescale 1ns/10ps
// How it works
// - Bit 6 enables back-channel CRC generator
// - Bit 5 selects pull-down, else pull-up
// - Bit 4 rejects strobe pulses under two pixels
// - Bit 3 forwards alias-matching transactions remotely
// - Bit 2 acknowledges regardless of lock
// - Bit 1 gates colour data by valid
// - Watchdog timeout in two-millisecond steps
// - Abort transaction exceeding watchdog timeout
// - Watchdog bit 0 set disables watchdog
// - Pass-all bit forwards every local transaction
// - SDA hold time in 50 ns steps
// - Glitch filter width in 5 ns steps
// - Alias address replaced by physical address
module dcc_channel_config_regs
    import dcc_pkg::*;
#(
    parameter int NUM_ALIAS     = 8,
    parameter int WDOG_STEP_CLK = WDOG_STEP_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    output logic      [7:0]            regRdData,
    output logic                       crcGenEnable,
    output logic                       pullDownSel,
    input  wire logic                  pixClkEn,
    input  wire dcc_pixel_t            pixIn,
    output dcc_pixel_t                 pixOut,
    input  wire logic                  txnStart,
    input  wire logic [6:0]            txnAddr,
    input  wire dcc_alias_t            aliasTable [NUM_ALIAS],
    input  wire logic                  fwdLocked,
    output logic                       txnForward,
    output logic      [6:0]            txnFwdAddr,
    output logic                       txnAck,
    input  wire logic                  txnActive,
    output logic                       txnAbort,
    input  wire logic                  sclIn,
    input  wire logic                  sdaIn,
    output logic                       sclClean,
    output logic                       sdaClean
);
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // Stability filter step: level follows input after lim stable samples
    function automatic logic [FLT_CNT_W:0] fltStep(
        input logic din, input logic lvl,
        input logic [FLT_CNT_W-1:0] cnt, input logic [FLT_CNT_W-1:0] lim);
        logic [FLT_CNT_W-1:0] nxt;
        nxt = cnt + 1'b1;
        if (din == lvl) begin
            fltStep = {lvl, {FLT_CNT_W{1'b0}}};
        end else if (nxt >= lim) begin
            fltStep = {din, {FLT_CNT_W{1'b0}}};
        end else begin
            fltStep = {lvl, nxt};
        end
    endfunction : fltStep
    // Nanoseconds to mclk cycles, rounded up
    function automatic logic [FLT_CNT_W-1:0] nsToCyc(input int ns);
        nsToCyc = FLT_CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : nsToCyc
    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [7:0] genCfg_reg,  genCfg_next;
    logic [7:0] wdogCtl_reg, wdogCtl_next;
    logic [7:0] busCtl_reg,  busCtl_next;
    logic [7:0] rdData_reg,  rdData_next;
    // Write decode and registered read; unmapped reads return zero
    always_comb begin
        genCfg_next  = genCfg_reg;
        wdogCtl_next = wdogCtl_reg;
        busCtl_next  = busCtl_reg;
        rdData_next  = rdData_reg;
        if (regWrEn) begin
            case (regAddr)
                GEN_CFG_ONE_OFS:  genCfg_next = (regWrData & GEN_CFG_ONE_WMSK)
                    | (GEN_CFG_ONE_RST & ~GEN_CFG_ONE_WMSK);
                WDOG_CTRL_OFS:    wdogCtl_next = regWrData;
                BUS_CTRL_ONE_OFS: busCtl_next  = regWrData;
                default:          ;
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                GEN_CFG_ONE_OFS:  rdData_next = genCfg_reg;
                WDOG_CTRL_OFS:    rdData_next = wdogCtl_reg;
                BUS_CTRL_ONE_OFS: rdData_next = busCtl_reg;
                default:          rdData_next = READ_UNMAPPED;
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            genCfg_reg  <= GEN_CFG_ONE_RST;
            wdogCtl_reg <= WDOG_CTRL_RST;
            busCtl_reg  <= BUS_CTRL_ONE_RST;
            rdData_reg  <= READ_UNMAPPED;
        end else begin
            genCfg_reg  <= genCfg_next;
            wdogCtl_reg <= wdogCtl_next;
            busCtl_reg  <= busCtl_next;
            rdData_reg  <= rdData_next;
        end
    end
    assign regRdData    = rdData_reg;
    assign crcGenEnable = genCfg_reg[CRC_GEN_BIT];
    assign pullDownSel  = genCfg_reg[PULL_DOWN_BIT];
    // -----------------------------------------------------------------
    // Strobe filter and pixel gating
    // -----------------------------------------------------------------
    // Filtered levels advance only on pixel-clock enables, so a pulse
    // must be seen for two whole pixel periods before it is accepted.
    logic [2:0]           strbLvl_reg, strbLvl_next;
    logic [FLT_CNT_W-1:0] strbCnt_reg [3];
    logic [FLT_CNT_W-1:0] strbCnt_next [3];
    dcc_pixel_t           pix_reg, pix_next;
    logic [2:0]           strbRaw;
    logic [FLT_CNT_W:0]   strbStep;
    logic [2:0]           strbUse;
    assign strbRaw = {pixIn.pixelValidStrobe, pixIn.horizontalSync,
                      pixIn.verticalSync};
    always_comb begin
        strbLvl_next = strbLvl_reg;
        strbCnt_next = strbCnt_reg;
        strbStep     = '0;
        for (int i = 0; i < 3; i++) begin
            strbStep = fltStep(strbRaw[i], strbLvl_reg[i], strbCnt_reg[i],
                               FLT_CNT_W'(STROBE_MIN_PIX));
            if (pixClkEn) begin
                strbLvl_next[i] = strbStep[FLT_CNT_W];
                strbCnt_next[i] = strbStep[FLT_CNT_W-1:0];
            end
        end
        // Bypass uses the raw strobes directly
        strbUse = genCfg_reg[STROBE_FLT_BIT] ? strbLvl_next
                                             : strbRaw;
        pix_next = pix_reg;
        if (pixClkEn) begin
            pix_next.pixelValidStrobe = strbUse[2];
            pix_next.horizontalSync   = strbUse[1];
            pix_next.verticalSync     = strbUse[0];
            pix_next.rgb = (genCfg_reg[GATE_PIX_BIT] && !strbUse[2])
                ? 24'h000000 : pixIn.rgb;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            strbLvl_reg <= 3'h0;
            strbCnt_reg <= '{default: '0};
            pix_reg     <= '0;
        end else begin
            strbLvl_reg <= strbLvl_next;
            strbCnt_reg <= strbCnt_next;
            pix_reg     <= pix_next;
        end
    end
    assign pixOut = pix_reg;
    // -----------------------------------------------------------------
    // Forwarding decision
    // -----------------------------------------------------------------
    logic       fwd_reg,  fwd_next;
    logic [6:0] fwdA_reg, fwdA_next;
    logic       ack_reg,  ack_next;
    logic       aliasHit;
    logic [6:0] aliasPhys;
    // Lowest-numbered matching alias wins if several match
    always_comb begin
        aliasHit  = 1'b0;
        aliasPhys = txnAddr;
        for (int i = NUM_ALIAS - 1; i >= 0; i--) begin
            if (aliasTable[i].aliasAddressEntry == txnAddr) begin
                aliasHit  = 1'b1;
                aliasPhys = aliasTable[i].physicalAddress;
            end
        end
        fwd_next  = fwd_reg;
        fwdA_next = fwdA_reg;
        ack_next  = ack_reg;
        if (txnStart) begin
            fwd_next = busCtl_reg[PASS_ALL_BIT]
                || (genCfg_reg[PASS_ALIAS_BIT] && aliasHit);
            fwdA_next = aliasHit ? aliasPhys : txnAddr;
            ack_next  = fwdLocked || genCfg_reg[AUTO_ACK_BIT];
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            fwd_reg  <= 1'b0;
            fwdA_reg <= 7'h00;
            ack_reg  <= 1'b0;
        end else begin
            fwd_reg  <= fwd_next;
            fwdA_reg <= fwdA_next;
            ack_reg  <= ack_next;
        end
    end
    assign txnForward = fwd_reg;
    assign txnFwdAddr = fwdA_reg;
    assign txnAck     = ack_reg;
    // -----------------------------------------------------------------
    // Control-channel watchdog
    // -----------------------------------------------------------------
    // A zero timeout is not protected against: the step count wraps
    // through 127 first, so the abort comes very late.
    logic [31:0] pre_reg,   pre_next;
    logic [6:0]  steps_reg, steps_next;
    logic        done_reg,  done_next;
    logic        abort_reg, abort_next;
    logic        wdogTick;
    always_comb begin
        pre_next   = pre_reg;
        steps_next = steps_reg;
        done_next  = done_reg;
        abort_next = 1'b0;
        wdogTick   = (pre_reg == 32'(WDOG_STEP_CLK - 1));
        if (!txnActive || wdogCtl_reg[WDOG_OFF_BIT]) begin
            pre_next   = 32'h00000000;
            steps_next = 7'h00;
            done_next  = 1'b0;
        end else if (!done_reg) begin
            pre_next = wdogTick ? 32'h00000000 : pre_reg + 32'h00000001;
            if (wdogTick) begin
                steps_next = steps_reg + 7'h01;
                if (steps_next == wdogCtl_reg[WDOG_TMO_MSB:WDOG_TMO_LSB]) begin
                    abort_next = 1'b1;
                    done_next  = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            pre_reg   <= 32'h00000000;
            steps_reg <= 7'h00;
            done_reg  <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            pre_reg   <= pre_next;
            steps_reg <= steps_next;
            done_reg  <= done_next;
            abort_reg <= abort_next;
        end
    end
    assign txnAbort = abort_reg;
    // -----------------------------------------------------------------
    // SCL/SDA glitch filter and SDA hold
    // -----------------------------------------------------------------
    logic [1:0]            busLvl_reg, busLvl_next;
    logic [FLT_CNT_W-1:0]  busCnt_reg [2];
    logic [FLT_CNT_W-1:0]  busCnt_next [2];
    logic [HOLD_TAPS-1:0]  sdaDly_reg, sdaDly_next;
    logic [FLT_CNT_W-1:0]  glitchLim;
    logic [FLT_CNT_W:0]    busStep;
    logic [5:0]            holdTap;
    always_comb begin
        // Accept a level only once it outlasts the widest glitch
        glitchLim = nsToCyc(int'(busCtl_reg[GLITCH_MSB:GLITCH_LSB])
                            * GLITCH_STEP_NS) + 1'b1;
        busLvl_next = busLvl_reg;
        busCnt_next = busCnt_reg;
        busStep     = fltStep(sclIn, busLvl_reg[1], busCnt_reg[1], glitchLim);
        busLvl_next[1] = busStep[FLT_CNT_W];
        busCnt_next[1] = busStep[FLT_CNT_W-1:0];
        busStep     = fltStep(sdaIn, busLvl_reg[0], busCnt_reg[0], glitchLim);
        busLvl_next[0] = busStep[FLT_CNT_W];
        busCnt_next[0] = busStep[FLT_CNT_W-1:0];
        // Tap 0 mirrors the filtered level, so a zero hold adds no lag
        sdaDly_next = {sdaDly_reg[HOLD_TAPS-2:0], busLvl_next[0]};
        holdTap = 6'(nsToCyc(int'(busCtl_reg[SDA_HOLD_MSB:SDA_HOLD_LSB])
                             * SDA_HOLD_NS));
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            busLvl_reg <= 2'h3;
            busCnt_reg <= '{default: '0};
            sdaDly_reg <= '1;
        end else begin
            busLvl_reg <= busLvl_next;
            busCnt_reg <= busCnt_next;
            sdaDly_reg <= sdaDly_next;
        end
    end
    // SDA is taken from the delay line so it lags SCL by the hold time
    assign sclClean = busLvl_reg[1];
    assign sdaClean = sdaDly_reg[holdTap];
endmodule : dcc_channel_config_regs

// >>> tb/dcc_regs_chk.sv
// Checker for the channel config bank, bound to its top module.
// Keeps its own shadow of the three registers from the write strobes.
`timescale 1ns/10ps
module dcc_regs_chk
    import dcc_pkg::*;
#(
    parameter int WDOG_STEP_CLK = 4
) (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       crcGenEnable,
    input wire logic       pullDownSel,
    input wire logic       pixClkEn,
    input wire dcc_pixel_t pixIn,
    input wire dcc_pixel_t pixOut,
    input wire logic       txnStart,
    input wire logic       fwdLocked,
    input wire logic       txnForward,
    input wire logic       txnAck,
    input wire logic       txnActive,
    input wire logic       txnAbort,
    input wire logic       sclIn,
    input wire logic       sclClean
);
    logic [7:0]  genReg, wdReg, busReg, rdExp;
    int unsigned actCnt, wdLim;
    // Shadow registers; reserved bits of 0x03 keep their reset level
    always_ff @(posedge mclk) begin
        if (srst) begin
            genReg <= GEN_CFG_ONE_RST;
            wdReg  <= WDOG_CTRL_RST;
            busReg <= BUS_CTRL_ONE_RST;
        end else if (regWrEn) begin
            if (regAddr == GEN_CFG_ONE_OFS)
                genReg <= (regWrData & GEN_CFG_ONE_WMSK)
                        | (GEN_CFG_ONE_RST & ~GEN_CFG_ONE_WMSK);
            if (regAddr == WDOG_CTRL_OFS)
                wdReg <= regWrData;
            if (regAddr == BUS_CTRL_ONE_OFS)
                busReg <= regWrData;
        end
    end
    // Armed active cycles; a count avoids a huge repetition operator
    always_ff @(posedge mclk) begin
        if (srst || !txnActive || wdReg[WDOG_OFF_BIT])
            actCnt <= 0;
        else
            actCnt <= actCnt + 1;
    end
    assign wdLim = WDOG_STEP_CLK
                 * ((wdReg[7:1] == 7'h00) ? 128 : int'(wdReg[7:1]));
    assign rdExp = (regAddr == GEN_CFG_ONE_OFS)  ? genReg :
                   (regAddr == WDOG_CTRL_OFS)    ? wdReg  :
                   (regAddr == BUS_CTRL_ONE_OFS) ? busReg : READ_UNMAPPED;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_crc_level: assert property (
        crcGenEnable == genReg[CRC_GEN_BIT])
        else $error("crc enable differs from register");
    a_pull_level: assert property (
        pullDownSel == genReg[PULL_DOWN_BIT])
        else $error("pull select differs from register");
    a_rd_value: assert property (
        regRdEn |=> regRdData == $past(rdExp))
        else $error("read data wrong");
    // All three strobes (valid, line and frame sync) pass raw when off
    a_flt_off: assert property (pixClkEn && !genReg[STROBE_FLT_BIT]
        |=> pixOut[26:24] == $past(pixIn[26:24]))
        else $error("unfiltered strobe not passed");
    a_gate_rgb: assert property (pixClkEn && genReg[GATE_PIX_BIT]
        |=> pixOut.pixelValidStrobe || pixOut.rgb == 24'h000000)
        else $error("colour not gated");
    a_fwd_all: assert property (txnStart && busReg[PASS_ALL_BIT]
        |=> txnForward) else $error("pass-all not forwarded");
    a_fwd_none: assert property (txnStart && !busReg[PASS_ALL_BIT]
        && !genReg[PASS_ALIAS_BIT] |=> !txnForward)
        else $error("forwarded while pass modes off");
    a_ack_rule: assert property (txnStart |=> txnAck ==
        ($past(fwdLocked) || $past(genReg[AUTO_ACK_BIT])))
        else $error("ack decision wrong");
    a_abort_time: assert property (
        txnAbort == (actCnt == wdLim))
        else $error("abort at wrong cycle");
    a_abort_off: assert property ($past(wdReg[WDOG_OFF_BIT])
        && wdReg[WDOG_OFF_BIT] |-> !txnAbort)
        else $error("abort while disabled");
    a_scl_pass: assert property (busReg[3:0] == 4'h0
        && $past(busReg[3:0]) == 4'h0 |=> sclClean == $past(sclIn))
        else $error("zero-depth filter delays scl");

    c_abort: cover property (txnAbort);
    c_fwd: cover property (txnStart ##1 txnForward);
    c_gate: cover property (pixClkEn && genReg[GATE_PIX_BIT]);
endmodule : dcc_regs_chk

bind dcc_channel_config_regs dcc_regs_chk #(
    .WDOG_STEP_CLK(WDOG_STEP_CLK)
) u_chk (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .crcGenEnable(crcGenEnable), .pullDownSel(pullDownSel),
    .pixClkEn(pixClkEn), .pixIn(pixIn), .pixOut(pixOut),
    .txnStart(txnStart), .fwdLocked(fwdLocked), .txnForward(txnForward),
    .txnAck(txnAck), .txnActive(txnActive), .txnAbort(txnAbort),
    .sclIn(sclIn), .sclClean(sclClean)
);

// >>> tb/dcc_host_model.sv
// Local host stand-in: starts transactions, holds one outstanding.
// Assumes the bench calls its tasks from its own clocked sequence.
`timescale 1ns/10ps
module dcc_host_model (
    input  wire logic       mclk,
    output logic            txnStart,
    output logic      [6:0] txnAddr,
    output logic            txnActive
);
    initial begin
        txnStart  = 1'b0;
        txnAddr   = 7'h00;
        txnActive = 1'b0;
    end
    // One-cycle strobe; released address is inverted so stale use shows
    task automatic ask(input logic [6:0] a);
        @(posedge mclk);
        txnStart <= 1'b1;
        txnAddr  <= a;
        @(posedge mclk);
        txnStart <= 1'b0;
        txnAddr  <= ~a;
    endtask : ask
    // Keep a control-channel transaction outstanding for n cycles
    task automatic busy(input int n);
        @(posedge mclk);
        txnActive <= 1'b1;
        repeat (n) @(posedge mclk);
        txnActive <= 1'b0;
    endtask : busy
endmodule : dcc_host_model

// >>> tb/dcc_channel_config_regs_test.sv
// Self-checking bench for the channel config bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module dcc_channel_config_regs_test
    import dcc_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic pixClkEn = 1'b0, fwdLocked = 1'b0, sclIn = 1'b1, sdaIn = 1'b1;
    logic crcGenEnable, pullDownSel, txnStart, txnForward, txnAck;
    logic txnActive, txnAbort, sclClean, sdaClean;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [6:0] txnAddr, txnFwdAddr;
    dcc_pixel_t pixIn = '0, pixOut;
    dcc_alias_t alTab [2] = '{{7'h20, 7'h50}, {7'h20, 7'h51}};
    int errorCnt = 0, nTests = 0, abortCnt = 0;

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (txnAbort === 1'b1) abortCnt++;

    dcc_channel_config_regs #(.NUM_ALIAS(2), .WDOG_STEP_CLK(4)) u_dut (
        .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .crcGenEnable(crcGenEnable), .pullDownSel(pullDownSel),
        .pixClkEn(pixClkEn), .pixIn(pixIn), .pixOut(pixOut),
        .txnStart(txnStart), .txnAddr(txnAddr), .aliasTable(alTab),
        .fwdLocked(fwdLocked), .txnForward(txnForward),
        .txnFwdAddr(txnFwdAddr), .txnAck(txnAck), .txnActive(txnActive),
        .txnAbort(txnAbort), .sclIn(sclIn), .sdaIn(sdaIn),
        .sclClean(sclClean), .sdaClean(sdaClean));
    dcc_host_model u_host (.mclk(mclk), .txnStart(txnStart),
        .txnAddr(txnAddr), .txnActive(txnActive));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask : wr
    // Read data is looked at once the edge after the strobe has landed
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, e);
    endtask : rd
    task automatic px(input logic v, input logic [23:0] d,
                      input logic ev, input logic [23:0] ed);
        @(posedge mclk);
        // Both syncs follow valid so every strobe filter is exercised
        pixIn    <= {v, v, v, d};
        pixClkEn <= 1'b1;
        @(posedge mclk);
        pixClkEn <= 1'b0;
        #1 chk(pixOut, {ev, ev, ev, ed});
    endtask : px
    task automatic fwd(input logic [7:0] c3, input logic [7:0] c5,
                       input logic lk, input logic [6:0] a, input logic ef,
                       input logic [6:0] ea, input logic ek);
        wr(GEN_CFG_ONE_OFS, c3);
        wr(BUS_CTRL_ONE_OFS, c5);
        fwdLocked <= lk;
        u_host.ask(a);
        #1 chk({txnForward, txnFwdAddr, txnAck}, {ef, ea, ek});
    endtask : fwd
    task automatic wd(input logic [7:0] v, input int n, input int e);
        wr(WDOG_CTRL_OFS, v);
        abortCnt = 0;
        u_host.busy(n);
        repeat (3) @(posedge mclk);
        chk(abortCnt, e);
    endtask : wd
    task automatic stopTest();
        if (errorCnt == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stopTest

    // Whole run is under two hundred cycles; the limit leaves wide margin
    initial begin
        #50us;
        errorCnt++;
        stopTest();
    end
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        rd(GEN_CFG_ONE_OFS, GEN_CFG_ONE_RST);
        rd(WDOG_CTRL_OFS, WDOG_CTRL_RST);
        rd(BUS_CTRL_ONE_OFS, BUS_CTRL_ONE_RST);
        chk({crcGenEnable, pullDownSel}, 2'b11);
        wr(GEN_CFG_ONE_OFS, 8'h00);
        rd(GEN_CFG_ONE_OFS, 8'h80);
        chk({crcGenEnable, pullDownSel}, 2'b00);
        wr(GEN_CFG_ONE_OFS, 8'hFF);
        rd(GEN_CFG_ONE_OFS, 8'hFE);
        wr(WDOG_CTRL_OFS, 8'h55);
        rd(WDOG_CTRL_OFS, 8'h55);
        wr(BUS_CTRL_ONE_OFS, 8'hA5);
        wr(8'h06, 8'hFF);
        rd(8'h06, READ_UNMAPPED);
        rd(BUS_CTRL_ONE_OFS, 8'hA5);
        fwd(8'h08, 8'h00, 1'b0, 7'h20, 1'b1, 7'h50, 1'b0);
        fwd(8'h08, 8'h00, 1'b1, 7'h33, 1'b0, 7'h33, 1'b1);
        fwd(8'h04, 8'h80, 1'b0, 7'h33, 1'b1, 7'h33, 1'b1);
        fwd(8'h00, 8'h00, 1'b0, 7'h33, 1'b0, 7'h33, 1'b0);
        wd(8'h04, 20, 1);
        wd(8'h04, 5, 0);
        wd(8'h05, 20, 0);
        wr(GEN_CFG_ONE_OFS, 8'h12);
        px(1'b0, 24'h123456, 1'b0, 24'h000000);
        px(1'b1, 24'h123456, 1'b0, 24'h000000);
        px(1'b0, 24'h123456, 1'b0, 24'h000000);
        px(1'b1, 24'hABCDEF, 1'b0, 24'h000000);
        px(1'b1, 24'hABCDEF, 1'b1, 24'hABCDEF);
        wr(GEN_CFG_ONE_OFS, 8'h00);
        px(1'b0, 24'h5A5A5A, 1'b0, 24'h5A5A5A);
        px(1'b1, 24'h5A5A5A, 1'b1, 24'h5A5A5A);
        wr(BUS_CTRL_ONE_OFS, 8'h00);
        @(posedge mclk) sclIn <= 1'b0;
        @(posedge mclk) #1 chk(sclClean, 1'b0);
        wr(BUS_CTRL_ONE_OFS, 8'h02);
        @(posedge mclk) sclIn <= 1'b1;
        repeat (3) @(posedge mclk);
        sclIn <= 1'b0;
        @(posedge mclk) sclIn <= 1'b1;
        repeat (4) @(posedge mclk) #1 chk(sclClean, 1'b1);
        wr(BUS_CTRL_ONE_OFS, 8'h10);
        repeat (3) @(posedge mclk);
        sdaIn <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 chk(sdaClean, 1'b1);
        @(posedge mclk) #1 chk(sdaClean, 1'b0);
        stopTest();
    end
endmodule : dcc_channel_config_regs_test
